/* File: fls_defs.svh */
// constants for the programmable logic slice: sizes, routing bundle layout, reset values
`ifndef FLS_DEFS_SVH
`define FLS_DEFS_SVH

////////////////////////////////////////////////////////////////////////////////
// lookup table geometry
`define FLS_LUT_SIZE    16
`define FLS_LUT_IN      4

////////////////////////////////////////////////////////////////////////////////
// routing bundle, bit positions of each group after the input synchroniser
`define FLS_RT_L0       0
`define FLS_RT_L1       4
`define FLS_RT_MPI      8
`define FLS_RT_WIDE     10
`define FLS_RT_CE       12
`define FLS_RT_LSR      13
`define FLS_RT_CLK      14
`define FLS_RT_CIN      15
`define FLS_RT_WAD      16
`define FLS_RT_WDI      20
`define FLS_RT_WRE      24
`define FLS_RT_W        25

////////////////////////////////////////////////////////////////////////////////
// slice roles within the logic block
`define FLS_SLICE_LAST  3
`define FLS_MEM_SLICES  2
`define FLS_CTRL_SLICE  2

////////////////////////////////////////////////////////////////////////////////
// reset values
`define FLS_RST_REG     2'h0
`define FLS_RST_TABLE   16'h0000

`endif

/* File: fls_pkg.sv */
// types shared by the logic slice modules
`include "fls_defs.svh"

package fls_pkg;

   typedef enum logic [1:0] {
      FLS_MODE_LOGIC  = 2'h0,
      FLS_MODE_RIPPLE = 2'h1,
      FLS_MODE_ROM    = 2'h2,
      FLS_MODE_RAM    = 2'h3
   } fls_mode_t;

   typedef enum logic [2:0] {
      FLS_OP_ADD    = 3'h0,
      FLS_OP_SUB    = 3'h1,
      FLS_OP_ADDSUB = 3'h2,
      FLS_OP_UPCNT  = 3'h3,
      FLS_OP_DNCNT  = 3'h4,
      FLS_OP_UDCNT  = 3'h5,
      FLS_OP_MULT   = 3'h6,
      FLS_OP_CMP    = 3'h7
   } fls_op_t;

   typedef struct packed {
      logic [`FLS_RT_W-1:0] rt_s1;
      logic [`FLS_RT_W-1:0] rt_s2;
      logic                 clk_prev;
      logic                 cfg_done;
      fls_mode_t            mode;
      fls_op_t              op;
      logic                 lsr_async;
      logic                 lsr_set;
      logic                 clk_neg;
      logic                 clk_level;
      logic                 fast;
      logic [1:0]           cmp_sel;
      logic [1:0]           q;
      logic [1:0]           f;
      logic                 ofx_lo;
      logic                 ofx_hi;
      logic                 cout;
      logic                 gen;
      logic                 prop;
      logic [3:0]           mem_write_addr;
      logic [3:0]           wdi;
      logic                 mem_write_enable;
   } fls_state_t;

   typedef struct packed {
      logic [`FLS_LUT_SIZE-1:0] tbl0;
      logic [`FLS_LUT_SIZE-1:0] tbl1;
   } fls_mem_state_t;

endpackage : fls_pkg

/* File: fls_lut_mem.sv */
// the two 16-entry lookup tables of one slice, loadable and writable as memory
`timescale 1ns/10ps
`include "fls_defs.svh"

module fls_lut_mem
   import fls_pkg::*;
(
   input  wire logic                     clk_in,
   input  wire logic                     rst_in,
   input  wire logic                     load_in,
   input  wire logic [`FLS_LUT_SIZE-1:0] load0_in,
   input  wire logic [`FLS_LUT_SIZE-1:0] load1_in,
   input  wire logic                     wr_en_in,
   input  wire logic [`FLS_LUT_IN-1:0]   wr_addr_in,
   input  wire logic [1:0]               wr_data_in,
   output logic      [`FLS_LUT_SIZE-1:0] tbl0_out,
   output logic      [`FLS_LUT_SIZE-1:0] tbl1_out
);

   fls_mem_state_t           s_q;
   fls_mem_state_t           s_d;
   logic [`FLS_LUT_SIZE-1:0] hit;

   ////////////////////////////////////////////////////////////////////////////
   genvar e;
   generate
      for (e = 0; e < `FLS_LUT_SIZE; e++) begin : g_hit
         assign hit[e] = wr_en_in && (wr_addr_in == 4'(e));
      end
   endgenerate

   // configuration load wins over a user write in the same cycle
   always_comb begin
      s_d = s_q;
      if (load_in) begin
         s_d.tbl0 = load0_in;
         s_d.tbl1 = load1_in;
      end else begin
         s_d.tbl0 = (s_q.tbl0 & ~hit) | (hit & {`FLS_LUT_SIZE{wr_data_in[0]}});
         s_d.tbl1 = (s_q.tbl1 & ~hit) | (hit & {`FLS_LUT_SIZE{wr_data_in[1]}});
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q.tbl0 <= `FLS_RST_TABLE;
         s_q.tbl1 <= `FLS_RST_TABLE;
      end else begin
         s_q <= s_d;
      end
   end

   assign tbl0_out = s_q.tbl0;
   assign tbl1_out = s_q.tbl1;

endmodule : fls_lut_mem

/* File: fls_ripple.sv */
// two-bit ripple arithmetic cell: add, subtract, count, multiply step, compare
`timescale 1ns/10ps

module fls_ripple
   import fls_pkg::*;
(
   input  wire fls_op_t    op_in,
   input  wire logic       dir_in,
   input  wire logic [1:0] a_in,
   input  wire logic [1:0] b_in,
   input  wire logic [1:0] cnt_in,
   input  wire logic       carry_in,
   output logic      [1:0] sum_out,
   output logic            carry_out,
   output logic            gen_out,
   output logic            prop_out,
   output logic            ge_out,
   output logic            ne_out,
   output logic            le_out
);

   logic [1:0] x;
   logic [1:0] y;
   logic       c;
   logic [2:0] total;
   logic [1:0] g;
   logic [1:0] p;

   // counters treat carry_in high as "count this step", in both directions
   always_comb begin
      x = a_in;
      y = b_in;
      c = carry_in;
      case (op_in)
         FLS_OP_ADD: begin
            y = b_in;
         end
         FLS_OP_SUB: begin
            y = ~b_in;
         end
         FLS_OP_ADDSUB: begin
            y = dir_in ? b_in : ~b_in;
         end
         FLS_OP_UPCNT: begin
            x = cnt_in;
            y = 2'h0;
         end
         FLS_OP_DNCNT: begin
            x = cnt_in;
            y = 2'h3;
            c = ~carry_in;
         end
         FLS_OP_UDCNT: begin
            x = cnt_in;
            y = dir_in ? 2'h0 : 2'h3;
            c = dir_in ? carry_in : ~carry_in;
         end
         FLS_OP_MULT: begin
            x = a_in & {2{dir_in}};
         end
         default: begin
            y = ~b_in;
            c = 1'b1;
         end
      endcase
      total = {1'b0, x} + {1'b0, y} + {2'h0, c};
   end

   assign sum_out   = total[1:0];
   assign carry_out = total[2];
   assign g         = x & y;
   assign p         = x ^ y;
   assign gen_out   = g[1] | (p[1] & g[0]);
   assign prop_out  = p[1] & p[0];
   assign ge_out    = (a_in >= b_in);
   assign ne_out    = (a_in != b_in);
   assign le_out    = (a_in <= b_in);

endmodule : fls_ripple

/* File: fls_slice.sv */
// one programmable logic slice: two lookup tables, two registers, ripple cell
`timescale 1ns/10ps
`include "fls_defs.svh"

module fls_slice
   import fls_pkg::*;
#(
   parameter int SLICE_ID = 0
) (
   input  wire logic        clk_in,
   input  wire logic        rst_in,
   input  wire logic        cfg_load_in,
   input  wire logic [15:0] cfg_lut0_in,
   input  wire logic [15:0] cfg_lut1_in,
   input  wire logic [1:0]  cfg_mode_in,
   input  wire logic [2:0]  cfg_op_in,
   input  wire logic [1:0]  cfg_init_in,
   input  wire logic        cfg_lsr_async_in,
   input  wire logic        cfg_lsr_set_in,
   input  wire logic        cfg_clk_neg_in,
   input  wire logic        cfg_clk_level_in,
   input  wire logic        cfg_fast_carry_in,
   input  wire logic [1:0]  cfg_cmp_sel_in,
   input  wire logic [3:0]  lut0_data_in,
   input  wire logic [3:0]  lut1_data_in,
   input  wire logic [1:0]  multi_purpose_in,
   input  wire logic [1:0]  wide_mux_in,
   input  wire logic        clock_enable_in,
   input  wire logic        local_set_reset_in,
   input  wire logic        slice_clock_in,
   input  wire logic        carry_in,
   input  wire logic [3:0]  mem_write_addr_in,
   input  wire logic [3:0]  mem_write_data_in,
   input  wire logic        mem_write_enable_in,
   output logic             comb_out0_out,
   output logic             comb_out1_out,
   output logic             reg_out0_out,
   output logic             reg_out1_out,
   output logic             wide_mux_out_lo_out,
   output logic             wide_mux_out_hi_out,
   output logic             carry_out_out,
   output logic             carry_gen_out,
   output logic             carry_prop_out,
   output logic [3:0]       mem_write_addr_out,
   output logic [3:0]       mem_write_data_out,
   output logic             mem_write_enable_out,
   output logic             user_mode_out
);

   localparam logic IS_MEM_SLICE  = (SLICE_ID < `FLS_MEM_SLICES);
   localparam logic IS_CTRL_SLICE = (SLICE_ID == `FLS_CTRL_SLICE);
   localparam logic IS_LAST_SLICE = (SLICE_ID == `FLS_SLICE_LAST);
   localparam logic DATA_UPPER    = (SLICE_ID == 1);

   fls_state_t           s_q;
   fls_state_t           s_d;
   logic [`FLS_RT_W-1:0] rt_raw;
   logic [`FLS_RT_W-1:0] rt;
   logic [3:0]           l0;
   logic [3:0]           l1;
   logic [1:0]           mpi;
   logic [1:0]           wide;
   logic                 ce_now;
   logic                 lsr_now;
   logic                 clk_now;
   logic                 cin_now;
   logic [3:0]           wad_in;
   logic [3:0]           wdi_in;
   logic                 wre_in;
   logic [15:0]          tbl0;
   logic [15:0]          tbl1;
   logic [1:0]           lut_f;
   logic                 edge_act;
   logic                 clk_act;
   logic                 mem_wr;
   logic [1:0]           mem_wd;
   logic [1:0]           lsr_val;
   logic                 ripple;
   logic                 counting;
   logic [1:0]           rp_a;
   logic [1:0]           rp_b;
   logic [1:0]           rp_sum;
   logic                 rp_cout;
   logic                 rp_gen;
   logic                 rp_prop;
   logic                 rp_ge;
   logic                 rp_ne;
   logic                 rp_le;
   logic                 cmp_bit;
   logic [1:0]           reg_d;

   ////////////////////////////////////////////////////////////////////////////
   // all routed inputs cross through two flops together so they stay aligned
   // routing and carry inputs
   assign rt_raw = {mem_write_enable_in, mem_write_data_in, mem_write_addr_in, carry_in,
                    slice_clock_in, local_set_reset_in, clock_enable_in, wide_mux_in,
                    multi_purpose_in, lut1_data_in, lut0_data_in};
   assign rt      = s_q.rt_s2;
   assign l0      = rt[`FLS_RT_L0 +: 4];
   assign l1      = rt[`FLS_RT_L1 +: 4];
   assign mpi     = rt[`FLS_RT_MPI +: 2];
   assign wide    = rt[`FLS_RT_WIDE +: 2];
   assign ce_now  = rt[`FLS_RT_CE];
   assign lsr_now = rt[`FLS_RT_LSR];
   assign clk_now = rt[`FLS_RT_CLK];
   assign cin_now = rt[`FLS_RT_CIN];
   assign wad_in  = rt[`FLS_RT_WAD +: 4];
   assign wdi_in  = rt[`FLS_RT_WDI +: 4];
   assign wre_in  = rt[`FLS_RT_WRE];

   ////////////////////////////////////////////////////////////////////////////
   // polarity and edge/level select
   assign edge_act = s_q.clk_neg ? (s_q.clk_prev & ~clk_now) : (~s_q.clk_prev & clk_now);
   assign clk_act  = s_q.clk_level ? (clk_now ^ s_q.clk_neg) : edge_act;

   ////////////////////////////////////////////////////////////////////////////
   // write on slice clock edge, enable from the memory write enable input
   assign mem_wr = IS_MEM_SLICE && (s_q.mode == FLS_MODE_RAM) && edge_act && wre_in;
   // upper data pair to slice 1, lower to slice 0
   assign mem_wd = DATA_UPPER ? wdi_in[3:2] : wdi_in[1:0];

   // address taken from the control slice
   fls_lut_mem u_mem (
      .clk_in     (clk_in),
      .rst_in     (rst_in),
      .load_in    (cfg_load_in),
      .load0_in   (cfg_lut0_in),
      .load1_in   (cfg_lut1_in),
      .wr_en_in   (mem_wr),
      .wr_addr_in (wad_in),
      .wr_data_in (mem_wd),
      .tbl0_out   (tbl0),
      .tbl1_out   (tbl1)
   );

   assign lut_f = {tbl1[l1], tbl0[l0]};

   ////////////////////////////////////////////////////////////////////////////
   // operands: A pins of both tables form a, B pins form b
   assign ripple   = (s_q.mode == FLS_MODE_RIPPLE);
   assign rp_a     = {l1[0], l0[0]};
   assign rp_b     = {l1[1], l0[1]};
   assign counting = (s_q.op == FLS_OP_UPCNT) || (s_q.op == FLS_OP_DNCNT)
                     || (s_q.op == FLS_OP_UDCNT);

   fls_ripple u_ripple (
      .op_in     (s_q.op),
      .dir_in    (mpi[0]),
      .a_in      (rp_a),
      .b_in      (rp_b),
      .cnt_in    (s_q.q),
      .carry_in  (cin_now),
      .sum_out   (rp_sum),
      .carry_out (rp_cout),
      .gen_out   (rp_gen),
      .prop_out  (rp_prop),
      .ge_out    (rp_ge),
      .ne_out    (rp_ne),
      .le_out    (rp_le)
   );

   always_comb begin
      case (s_q.cmp_sel)
         2'h0: begin
            cmp_bit = rp_ge;
         end
         2'h1: begin
            cmp_bit = rp_ne;
         end
         default: begin
            cmp_bit = rp_le;
         end
      endcase
   end

   // synchronous preload of a counter from operand a
   assign reg_d   = !ripple ? lut_f : ((counting && mpi[1]) ? rp_a : rp_sum);
   assign lsr_val = s_q.lsr_set ? 2'h3 : 2'h0;

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      s_d          = s_q;
      s_d.rt_s1    = rt_raw;
      s_d.rt_s2    = s_q.rt_s1;
      s_d.clk_prev = clk_now;
      if (cfg_load_in) begin
         // memory request on the last slice degrades to table-only use
         s_d.mode      = (IS_LAST_SLICE && cfg_mode_in == FLS_MODE_RAM) ? FLS_MODE_ROM
                                                                         : fls_mode_t'(cfg_mode_in);
         s_d.op        = fls_op_t'(cfg_op_in);
         s_d.lsr_async = cfg_lsr_async_in;
         s_d.lsr_set   = cfg_lsr_set_in;
         s_d.clk_neg   = cfg_clk_neg_in;
         s_d.clk_level = cfg_clk_level_in;
         s_d.fast      = cfg_fast_carry_in;
         s_d.cmp_sel   = cfg_cmp_sel_in;
         // registers enter user mode at configured value
         s_d.q         = cfg_init_in;
         s_d.cfg_done  = 1'b1;
      end else if (s_q.cfg_done) begin
         // asynchronous set/reset ignores clock and enable
         if (lsr_now && s_q.lsr_async) begin
            s_d.q = lsr_val;
         // clock enable gates every clocked register update, synchronous set/reset included
         end else if (ce_now && clk_act) begin
            // synchronous set/reset on the active clock
            s_d.q = lsr_now ? lsr_val : reg_d;
         end
      end
      // bypass outputs carry the table or arithmetic result
      if (ripple) begin
         s_d.f = (s_q.op == FLS_OP_CMP) ? {1'b0, cmp_bit} : rp_sum;
      end else begin
         s_d.f = lut_f;
      end
      s_d.ofx_lo = mpi[0] ? lut_f[1] : lut_f[0];
      // chained mux of neighbouring wide outputs
      s_d.ofx_hi = mpi[1] ? wide[1] : wide[0];
      // generate and propagate for fast carry
      s_d.cout   = ripple && rp_cout;
      s_d.gen    = ripple && s_q.fast && rp_gen;
      s_d.prop   = ripple && s_q.fast && rp_prop;
      // control slice exports its table inputs as memory address and data, its set/reset as write enable
      s_d.mem_write_addr    = IS_CTRL_SLICE ? l0 : 4'h0;
      s_d.wdi    = IS_CTRL_SLICE ? l1 : 4'h0;
      s_d.mem_write_enable    = IS_CTRL_SLICE && lsr_now;
   end

   // control state has a fixed value until the configuration load
   always_ff @(posedge clk_in) begin
      if (rst_in) begin
         s_q      <= '0;
         s_q.q    <= `FLS_RST_REG;
         s_q.mode <= FLS_MODE_LOGIC;
         s_q.op   <= FLS_OP_ADD;
      end else begin
         s_q <= s_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // six routing outputs, carry out with generate and propagate, memory controls and user mode
   assign comb_out0_out        = s_q.f[0];
   assign comb_out1_out        = s_q.f[1];
   assign reg_out0_out         = s_q.q[0];
   assign reg_out1_out         = s_q.q[1];
   assign wide_mux_out_lo_out  = s_q.ofx_lo;
   assign wide_mux_out_hi_out  = s_q.ofx_hi;
   assign carry_out_out        = s_q.cout;
   assign carry_gen_out        = s_q.gen;
   assign carry_prop_out       = s_q.prop;
   assign mem_write_addr_out   = s_q.mem_write_addr;
   assign mem_write_data_out   = s_q.wdi;
   assign mem_write_enable_out = s_q.mem_write_enable;
   assign user_mode_out        = s_q.cfg_done;

   ////////////////////////////////////////////////////////////////////////////
   // checks; the slice clock is emulated, so all relations are on clk_in
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);

   property p_ce_hold;
      (s_q.cfg_done && !cfg_load_in && !ce_now && !(lsr_now && s_q.lsr_async))
         |=> (s_q.q == $past(s_q.q));
   endproperty
   a_ce_hold : assert property (p_ce_hold) else $error("registers moved with enable low");

   property p_init;
      cfg_load_in |=> ({reg_out1_out, reg_out0_out} == $past(cfg_init_in));
   endproperty
   a_init : assert property (p_init) else $error("register not at configured value");

   property p_async_lsr;
      (s_q.cfg_done && !cfg_load_in && lsr_now && s_q.lsr_async)
         |=> ({reg_out1_out, reg_out0_out} == $past(lsr_val));
   endproperty
   a_async_lsr : assert property (p_async_lsr) else $error("async set/reset missed");

   property p_no_mem_last;
      !(IS_LAST_SLICE && s_q.mode == FLS_MODE_RAM) && (!mem_wr || IS_MEM_SLICE);
   endproperty
   a_no_mem_last : assert property (p_no_mem_last) else $error("illegal memory write");

   property p_wr_source;
      mem_wr |-> (wre_in && !s_q.clk_prev ^ s_q.clk_neg && clk_now ^ s_q.clk_neg);
   endproperty
   a_wr_source : assert property (p_wr_source) else $error("write not on slice clock edge");

   property p_wr_data;
      (mem_wr && !cfg_load_in) |=> (tbl0[$past(wad_in)] == $past(mem_wd[0]))
                                   && (tbl1[$past(wad_in)] == $past(mem_wd[1]));
   endproperty
   a_wr_data : assert property (p_wr_data) else $error("memory write data lost");

   property p_lut_read;
      (!ripple && !cfg_load_in) |=> (comb_out0_out == $past(tbl0[l0]))
                                    && (comb_out1_out == $past(tbl1[l1]));
   endproperty
   a_lut_read : assert property (p_lut_read) else $error("table output wrong");

   property p_lut5;
      1'b1 |=> (wide_mux_out_lo_out == ($past(mpi[0]) ? $past(lut_f[1]) : $past(lut_f[0])));
   endproperty
   a_lut5 : assert property (p_lut5) else $error("five-input mux wrong");

   property p_add;
      (ripple && s_q.op == FLS_OP_ADD && !cfg_load_in)
         |=> ({carry_out_out, comb_out1_out, comb_out0_out}
              == ({1'b0, $past(rp_a)} + {1'b0, $past(rp_b)} + {2'h0, $past(cin_now)}));
   endproperty
   a_add : assert property (p_add) else $error("ripple add wrong");

   property p_fast_off;
      !s_q.fast |=> !carry_gen_out && !carry_prop_out;
   endproperty
   a_fast_off : assert property (p_fast_off) else $error("carry terms without fast mode");

   c_mem_write : cover property (mem_wr);
   c_count     : cover property (ripple && counting && ce_now && clk_act);
   c_sync_lsr  : cover property (!s_q.lsr_async && lsr_now && ce_now && clk_act);

endmodule : fls_slice

/* File: fls_nbr_model.sv */
// routing neighbour model: drives the slice clock into the slice
`timescale 1ns/10ps
module fls_nbr_model (
   input  wire logic clk_in,
   input  wire logic rst_in,
   input  wire logic run_in,
   output logic      slice_clk_out
);
   logic [2:0] ph_q;
   ////////////////////////////////////////
   // four-cycle phases keep clear of the three-cycle minimum
   // clock stands low while not running, like an idle net
   always_ff @(posedge clk_in) begin
      if (rst_in || !run_in) begin
         ph_q <= 3'h0;
      end else begin
         ph_q <= ph_q + 3'h1;
      end
   end
   assign slice_clk_out = ph_q[2];
endmodule : fls_nbr_model

/* File: fls_slice_tb.sv */
// self-checking bench for one logic slice
`timescale 1ns/10ps
module fls_slice_tb;
   import fls_pkg::*;
   logic        clk_in, rst_in, cfg_load_in, cfg_lsr_async_in, cfg_lsr_set_in, cfg_fast_carry_in;
   logic        clock_enable_in, local_set_reset_in, carry_in, run, sclk;
   logic        f0, f1, q0, q1, lo, hi, co, um;
   logic [15:0] t0, t1;
   logic        cneg, lvl, we, cg, cp, weo;
   logic [1:0]  cfg_mode_in, cfg_init_in, cfg_cmp_sel_in, mpi, wide, a, b, gp;
   logic [2:0]  cfg_op_in, r;
   logic [3:0]  l0, l1, wa, wd, wao, wdo;
   int          seed, err_total, samples_checked, i;

   fls_nbr_model fls_nbr_model_i (.clk_in(clk_in), .rst_in(rst_in), .run_in(run),
      .slice_clk_out(sclk));
   fls_slice #(.SLICE_ID(0)) fls_slice_i (.clk_in(clk_in), .rst_in(rst_in),
      .cfg_load_in(cfg_load_in), .cfg_lut0_in(t0), .cfg_lut1_in(t1), .cfg_mode_in(cfg_mode_in),
      .cfg_op_in(cfg_op_in), .cfg_init_in(cfg_init_in), .cfg_lsr_async_in(cfg_lsr_async_in),
      .cfg_lsr_set_in(cfg_lsr_set_in), .cfg_clk_neg_in(cneg), .cfg_clk_level_in(lvl),
      .cfg_fast_carry_in(cfg_fast_carry_in), .cfg_cmp_sel_in(cfg_cmp_sel_in),
      .lut0_data_in(l0), .lut1_data_in(l1), .multi_purpose_in(mpi), .wide_mux_in(wide),
      .clock_enable_in(clock_enable_in), .local_set_reset_in(local_set_reset_in),
      .slice_clock_in(sclk), .carry_in(carry_in), .mem_write_addr_in(wa),
      .mem_write_data_in(wd), .mem_write_enable_in(we), .comb_out0_out(f0),
      .comb_out1_out(f1), .reg_out0_out(q0), .reg_out1_out(q1), .wide_mux_out_lo_out(lo),
      .wide_mux_out_hi_out(hi), .carry_out_out(co), .carry_gen_out(cg), .carry_prop_out(cp),
      .mem_write_addr_out(wao), .mem_write_data_out(wdo), .mem_write_enable_out(weo),
      .user_mode_out(um));

   ////////////////////////////////////////
   task automatic end_of_test;
      if (err_total == 0 && samples_checked > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : end_of_test

   task automatic chk(input logic [3:0] got, input logic [3:0] exp);
      samples_checked++;
      if (got !== exp) begin
         err_total++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   task automatic tick(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : tick

   task automatic cfg(input logic [1:0] md, input logic [2:0] op, input logic [1:0] sel);
      cfg_mode_in = md;
      cfg_op_in = op;
      cfg_cmp_sel_in = sel;
      cfg_load_in = 1'b1;
      tick(1);
      cfg_load_in = 1'b0;
      tick(5);
   endtask : cfg

   // a few slice clock periods, then the clock rests low
   task automatic clk_run;
      run = 1'b1;
      tick(16);
      run = 1'b0;
      tick(6);
   endtask : clk_run

   // two-bit sum with carry, or one compare result on bit 0
   function automatic logic [2:0] rip_exp(input logic [2:0] op, input logic [1:0] sel,
                                          input logic [1:0] a, input logic [1:0] b,
                                          input logic c, input logic dir);
      logic [1:0] y;
      y = (op == FLS_OP_SUB || (op == FLS_OP_ADDSUB && !dir)) ? ~b : b;
      if (op != FLS_OP_CMP) return {1'b0, a} + {1'b0, y} + {2'h0, c};
      if (sel == 2'h0) return {2'h0, a >= b};
      if (sel == 2'h1) return {2'h0, a != b};
      return {2'h0, a <= b};
   endfunction : rip_exp

   initial begin
      clk_in = 1'b0;
      forever #2 clk_in = ~clk_in;
   end

   initial begin
      #20000;
      err_total++;
      end_of_test();
   end

   ////////////////////////////////////////
   initial begin
      seed = 87522;
      err_total = 0;
      samples_checked = 0;
      rst_in = 1'b1;
      {cfg_load_in, cfg_lsr_async_in, cfg_lsr_set_in, cfg_fast_carry_in} = 4'h0;
      {clock_enable_in, local_set_reset_in, carry_in, run} = 4'h0;
      {cfg_mode_in, cfg_init_in, cfg_cmp_sel_in, mpi, wide, cfg_op_in} = 13'h0000;
      {l0, l1, wa, wd, cneg, lvl, we} = 19'h00000;
      t0 = 16'($random(seed));
      t1 = 16'($random(seed));
      tick(12);
      rst_in = 1'b0;
      tick(2);
      chk({um, q1, q0, f0}, 4'h0);
      cfg(FLS_MODE_LOGIC, FLS_OP_ADD, 2'h0);
      // table lookups and wide muxes
      for (i = 0; i < 24; i++) begin
         {l0, l1, mpi, wide} = 12'($random(seed));
         tick(5);
         chk({2'h0, f1, f0}, {2'h0, t1[l1], t0[l0]});
         chk({1'b0, lo, hi, co}, {1'b0, mpi[0] ? t1[l1] : t0[l0], wide[mpi[1]], 1'b0});
      end
      // ripple add, subtract, add/subtract, then all three compares
      cfg_fast_carry_in = 1'b1;
      for (i = 0; i < 24; i++) begin
         cfg(FLS_MODE_RIPPLE, (i < 12) ? 3'(i % 3) : FLS_OP_CMP, 2'(i % 3));
         {l0, l1, carry_in, mpi} = 11'($random(seed));
         if (i == 0) {l0, l1, carry_in, mpi} = 11'h7ff;
         tick(5);
         a = {l1[0], l0[0]};
         b = {l1[1], l0[1]};
         r = rip_exp(cfg_op_in, 2'(i % 3), a, b, carry_in, mpi[0]);
         chk({1'b0, (i < 12) ? co : 1'b0, f1, f0}, {1'b0, r});
         gp = {(a[1] & b[1]) | ((a[1] ^ b[1]) & a[0] & b[0]), &(a ^ b)};
         if (i < 12 && i % 3 == 0) chk({2'h0, cg, cp}, {2'h0, gp});
      end
      // register path: init value, enable hold, clocked capture, async set
      {l0, l1} = 8'($random(seed));
      t0[l0] = 1'b1;
      t1[l1] = 1'b0;
      cfg_init_in = 2'h2;
      cfg_lsr_async_in = 1'b1;
      cfg_lsr_set_in = 1'b1;
      cfg(FLS_MODE_LOGIC, FLS_OP_ADD, 2'h0);
      chk({1'b0, um, q1, q0}, 4'h6);
      clk_run();
      chk({2'h0, q1, q0}, 4'h2);
      clock_enable_in = 1'b1;
      clk_run();
      chk({2'h0, q1, q0}, 4'h1);
      clock_enable_in = 1'b0;
      local_set_reset_in = 1'b1;
      tick(5);
      chk({2'h0, q1, q0}, 4'h3);
      chk(wao | wdo | {3'h0, weo}, 4'h0);
      local_set_reset_in = 1'b0;
      clk_run();
      chk({2'h0, q1, q0}, 4'h3);
      // counter: two steps, then preload from operand a
      clock_enable_in = 1'b1;
      carry_in = 1'b1;
      mpi = 2'h0;
      cfg(FLS_MODE_RIPPLE, FLS_OP_UPCNT, 2'h0);
      clk_run();
      chk({2'h0, q1, q0}, {2'h0, cfg_init_in + 2'h2});
      mpi = 2'h2;
      clk_run();
      chk({2'h0, q1, q0}, {2'h0, l1[0], l0[0]});
      // level clock: idle low is inactive, then active once inverted
      mpi = 2'h0;
      lvl = 1'b1;
      cfg(FLS_MODE_LOGIC, FLS_OP_ADD, 2'h0);
      chk({2'h0, q1, q0}, {2'h0, cfg_init_in});
      cneg = 1'b1;
      cfg(FLS_MODE_LOGIC, FLS_OP_ADD, 2'h0);
      chk({2'h0, q1, q0}, {2'h0, t1[l1], t0[l0]});
      // memory write on slice clock rise, read back through the tables
      {cneg, lvl, clock_enable_in} = 3'h0;
      {wa, wd} = 8'($random(seed));
      wd[1:0] = ~{t1[wa], t0[wa]};
      we = 1'b1;
      cfg(FLS_MODE_RAM, FLS_OP_ADD, 2'h0);
      clk_run();
      we = 1'b0;
      {l0, l1} = {wa, wa};
      tick(5);
      chk({2'h0, f1, f0}, {2'h0, wd[1:0]});
      end_of_test();
   end
endmodule : fls_slice_tb
